// File: bms_filter.sv
// Security filter of a multi-master bus matrix with error capture
//
// Summary of operation
// R01: Configuration registers are reachable only by secure requests; others ignored.
// R02: Requester security bit travels with every forwarded transfer.
// R03: Slave error responses are recorded like checker denials.
// R04: Violations answer the master with error and set its status flag.
// R05: Secure interrupt raised only for masters whose error interrupt is enabled.
// R06: Offending address captured per master.
// R07: Region count fixed per slave, one to eight.
// R08: Five slave types; fixed types are not software changeable.
// R09: Always non-secure slave: no restriction, out of range denied.
// R10: Always secure slave: only secure requests pass.
// R11: Internal securable region splits into one non-secure and one secure area.
// R12: Split boundary is a power of two from 4 Kbytes to whole region.
// R13: Software chooses whether the lower area is secure.
// R14: Secure area independently read-protected and write-protected.
// R15: External securable region size programmable; beyond it denied.
// R16: Scalable slave: equal contiguous regions of software-set size.
// R17: Security type chosen per master and per slave.
// R18: Regions of different types coexist inside one slave.
// R19: Each APB peripheral has a secure-only select bit.
// R20: Denied requests are not forwarded; error answered instead.
`include "bms_params.svh"
module bms_filter
	import bms_pkg::*;
(
	input  wire logic                  i_clk,
	input  wire logic                  i_rst_n,
	input  wire bms_req_t              i_req,
	input  wire bms_serr_t             i_slv_err,
	input  wire logic [`BMS_RA_W-1:0]  i_reg_addr,
	input  wire logic [`BMS_DW-1:0]    i_reg_wdata,
	input  wire logic                  i_reg_wr,
	input  wire logic                  i_reg_rd,
	input  wire logic                  i_reg_secure,
	output logic      [`BMS_DW-1:0]    o_reg_rdata,
	output bms_fwd_t                   o_fwd,
	output logic      [`BMS_NUM_M-1:0] o_err_resp,
	output logic                       o_sec_irq
);

	// ------------------------------------------------------------
	// Design-time security type table
	// ------------------------------------------------------------
	// Types are fixed at build time; no register can change them
	// The DMA master sees the internal memory as always secure
	function automatic bms_stype_t stype_of(
		input logic [`BMS_MID_W-1:0] mid,
		input logic [`BMS_SID_W-1:0] sid
	);
		bms_stype_t t;
		t = BMS_ST_SEC;
		case (sid)
			`BMS_S_NS:  t = BMS_ST_NS;
			`BMS_S_SEC: t = BMS_ST_SEC;
			`BMS_S_INT: t = (mid == `BMS_DMA_MID) ? BMS_ST_SEC : BMS_ST_INT; // [R17]
			`BMS_S_EXT: t = BMS_ST_EXT;
			`BMS_S_SCL: t = BMS_ST_SCL;
			`BMS_S_APB: t = BMS_ST_NS;
			default:    t = BMS_ST_SEC;
		endcase
		return t;
	endfunction

	// Fixed base of each slave
	function automatic logic [`BMS_AW-1:0] base_of(input logic [`BMS_SID_W-1:0] sid);
		logic [`BMS_AW-1:0] b;
		b = `BMS_B_NS;
		case (sid)
			`BMS_S_NS:  b = `BMS_B_NS;
			`BMS_S_SEC: b = `BMS_B_SEC;
			`BMS_S_INT: b = `BMS_B_INT;
			`BMS_S_EXT: b = `BMS_B_EXT;
			`BMS_S_SCL: b = `BMS_B_SCL;
			`BMS_S_APB: b = `BMS_B_APB;
			default:    b = `BMS_B_NS;
		endcase
		return b;
	endfunction

	// Fixed window span of each slave
	function automatic logic [`BMS_AW-1:0] span_of(input logic [`BMS_SID_W-1:0] sid);
		logic [`BMS_AW-1:0] z;
		z = `BMS_Z_NS;
		case (sid)
			`BMS_S_NS:  z = `BMS_Z_NS;
			`BMS_S_SEC: z = `BMS_Z_SEC;
			`BMS_S_INT: z = `BMS_Z_INT;
			`BMS_S_EXT: z = `BMS_Z_EXT;
			`BMS_S_SCL: z = `BMS_Z_SCL;
			`BMS_S_APB: z = `BMS_Z_APB;
			default:    z = `BMS_Z_NS;
		endcase
		return z;
	endfunction

	// ------------------------------------------------------------
	// Registers
	// ------------------------------------------------------------
	// Register map, byte offsets on the register port:
	//   0x00 + 4*i  region word i: 0 internal, 1 external, 2..5 scalable regions 0..3
	//   0x20        error status, one bit per master, write one to clear
	//   0x24        error interrupt enable, one bit per master
	//   0x28 + 4*m  offending address of master m
	//   0x38        peripheral select, one bit per peripheral, set means secure only
	// Region word fields:
	//   split code    boundary is 4 Kbytes shifted left by the code
	//   lower secure  area below the boundary is the secure one
	//   read secured and write secured protect the secure area per direction
	//   size code     region size for external and scalable slaves, same scaling
	// Words 6 and 7 store what is written but steer no decision
	logic [`BMS_DW-1:0]    region_cfg [`BMS_NUM_CFG];
	logic [`BMS_NUM_M-1:0] err_stat;
	logic [`BMS_NUM_M-1:0] err_ien;
	logic [`BMS_AW-1:0]    err_addr [`BMS_NUM_M];
	logic [7:0]            apb_secure;
	logic [`BMS_DW-1:0]    next_rdata;
	logic                  sec_wr;
	logic                  sec_rd;

	// Non-secure register accesses have no effect and read zero
	assign sec_wr = i_reg_wr & i_reg_secure; // [R01]
	assign sec_rd = i_reg_rd & i_reg_secure; // [R01]

	// ------------------------------------------------------------
	// Access decision
	// ------------------------------------------------------------
	logic                   hit;
	logic [`BMS_SID_W-1:0]  sid;
	logic [`BMS_AW-1:0]     off;
	logic [`BMS_AW-1:0]     roff;
	logic [`BMS_AW-1:0]     rnum;
	logic [`BMS_CIDX_W-1:0] cidx;
	logic [`BMS_DW-1:0]     rcfg;
	logic [5:0]             size_sh;
	logic [5:0]             split_sh;
	logic                   oor;
	logic                   below;
	logic                   in_sec;
	logic                   prot;
	logic                   fix_sec;
	logic                   deny;
	bms_stype_t             st;

	// Slaves are tried in a fixed order and the first window holding the address wins.
	// The windows do not overlap, so the order never changes the result; an address in no window
	// is denied and reported like any other violation.
	// A subtraction and an unsigned compare check both ends of a window at once:
	// addresses below the base wrap round to a large offset and fail the compare.
	// Decode target slave, then apply its type's checks
	always_comb begin
		hit      = 1'b0;
		sid      = `BMS_S_NS;
		off      = '0;
		for (int s = 0; s < `BMS_NUM_S; s++) begin
			if (!hit && (i_req.addr - base_of(3'(s))) < span_of(3'(s))) begin
				hit = 1'b1;
				sid = 3'(s);
				off = i_req.addr - base_of(3'(s));
			end
		end
		st       = stype_of(i_req.mid, sid); // [R08]
		cidx     = `BMS_CI_INT;
		rnum     = '0;
		roff     = off;
		fix_sec  = 1'b0;
		oor      = 1'b0;
		case (st)
			BMS_ST_INT: begin
				cidx = `BMS_CI_INT; // [R11]
			end
			BMS_ST_EXT: begin
				cidx = `BMS_CI_EXT;
			end
			BMS_ST_SCL: begin
				cidx = `BMS_CI_SCL;
			end
			default: begin
				cidx = `BMS_CI_INT;
			end
		endcase
		rcfg     = region_cfg[cidx];
		// The slave's first region word carries the size code; scalable regions share it.
		// An offset past the configured size is denied, so no secure area is mirrored
		// into an open one when less memory is fitted than the window spans.
		size_sh  = {1'b0, rcfg[`BMS_F_SIZE]} + `BMS_MIN_SH;
		if (st == BMS_ST_EXT) begin
			oor = (off >> size_sh) != '0; // [R15]
		end
		if (st == BMS_ST_SCL) begin
			// Equal contiguous regions; index picks the region word
			rnum = off >> size_sh; // [R16]
			oor  = rnum >= `BMS_AW'(`BMS_NUM_SCL); // [R16]
			cidx = `BMS_CI_SCL + rnum[`BMS_CIDX_W-1:0]; // [R07]
			roff = off & ~(32'hFFFF_FFFF << size_sh);
			fix_sec = rnum[`BMS_CIDX_W-1:0] == `BMS_SCL_FIXSEC; // [R18]
		end
		rcfg     = region_cfg[cidx];
		split_sh = {1'b0, rcfg[`BMS_F_SPLIT]} + `BMS_MIN_SH; // [R12]
		below    = (roff >> split_sh) == '0; // [R12]
		in_sec   = below == rcfg[`BMS_F_LOWSEC]; // [R13]
		prot     = i_req.write ? rcfg[`BMS_F_WRSEC] : rcfg[`BMS_F_RDSEC]; // [R14]
		case (st)
			BMS_ST_NS:  deny = 1'b0; // [R09]
			BMS_ST_SEC: deny = !i_req.secure; // [R10]
			BMS_ST_INT,
			BMS_ST_EXT,
			BMS_ST_SCL: begin
				deny = oor | (fix_sec & !i_req.secure) | (in_sec & prot & !i_req.secure);
			end
			default:    deny = 1'b1;
		endcase
		if (sid == `BMS_S_APB && apb_secure[off[`BMS_APB_SH+2:`BMS_APB_SH]] && !i_req.secure) begin
			deny = 1'b1; // [R19]
		end
		if (!hit) begin
			deny = 1'b1; // [R09] [R10]
		end
	end

	// ------------------------------------------------------------
	// Forwarding
	// ------------------------------------------------------------
	// Only permitted requests reach the slave, with their security bit
	// A denied request still drives address and attributes, but valid stays low,
	// so the slave never starts a transfer for it.
	always_ff @(posedge i_clk) begin
		if (!i_rst_n) begin
			o_fwd <= '0;
		end else begin
			o_fwd.valid  <= i_req.valid & !deny; // [R20]
			o_fwd.sid    <= sid;
			o_fwd.addr   <= i_req.addr;
			o_fwd.write  <= i_req.write;
			o_fwd.secure <= i_req.secure; // [R02]
		end
	end

	// ------------------------------------------------------------
	// Per-master error capture
	// ------------------------------------------------------------
	genvar gm;
	generate
		for (gm = 0; gm < `BMS_NUM_M; gm++) begin : g_mst
			logic chk_hit;
			logic slv_hit;
			assign chk_hit = i_req.valid & deny & (i_req.mid == `BMS_MID_W'(gm));
			assign slv_hit = i_slv_err.valid & (i_slv_err.mid == `BMS_MID_W'(gm)); // [R03]

			// A checker denial and a slave error for one master may meet in one cycle;
			// both give a single error pulse and set the same flag.
			// Error answer to the master, checker or slave alike
			always_ff @(posedge i_clk) begin
				if (!i_rst_n) begin
					o_err_resp[gm] <= 1'b0;
				end else begin
					o_err_resp[gm] <= chk_hit | slv_hit; // [R04] [R20]
				end
			end

			// Sticky flag; a new error wins over a clear
			always_ff @(posedge i_clk) begin
				if (!i_rst_n) begin
					err_stat[gm] <= 1'b0;
				end else if (chk_hit | slv_hit) begin
					err_stat[gm] <= 1'b1; // [R04] [R03]
				end else if (sec_wr && i_reg_addr == `BMS_OFF_STAT && i_reg_wdata[gm]) begin
					err_stat[gm] <= 1'b0;
				end
			end

			// Offending address; the checker's own denial takes precedence
			always_ff @(posedge i_clk) begin
				if (!i_rst_n) begin
					err_addr[gm] <= '0;
				end else if (chk_hit) begin
					err_addr[gm] <= i_req.addr; // [R06]
				end else if (slv_hit) begin
					err_addr[gm] <= i_slv_err.addr; // [R06] [R03]
				end
			end
		end
	endgenerate

	// The enable gates the sticky flag, so enabling a master with a pending error
	// raises the interrupt one cycle later; clearing the flag drops it again.
	// Interrupt toward the secure world
	always_ff @(posedge i_clk) begin
		if (!i_rst_n) begin
			o_sec_irq <= 1'b0;
		end else begin
			o_sec_irq <= |(err_stat & err_ien); // [R05]
		end
	end

	// ------------------------------------------------------------
	// Register writes
	// ------------------------------------------------------------
	// Non-secure writes are dropped before they reach any register
	// Region configuration words
	always_ff @(posedge i_clk) begin
		if (!i_rst_n) begin
			for (int i = 0; i < `BMS_NUM_CFG; i++) begin
				region_cfg[i] <= `BMS_CFG_RST;
			end
		end else if (sec_wr) begin
			for (int i = 0; i < `BMS_NUM_CFG; i++) begin
				if (i_reg_addr == `BMS_OFF_CFG0 + `BMS_RA_W'(4 * i)) begin
					region_cfg[i] <= i_reg_wdata; // [R11] [R15]
				end
			end
		end
	end

	// Interrupt enable and APB peripheral security select
	always_ff @(posedge i_clk) begin
		if (!i_rst_n) begin
			err_ien    <= `BMS_IEN_RST;
			apb_secure <= `BMS_APB_RST;
		end else if (sec_wr) begin
			if (i_reg_addr == `BMS_OFF_IEN) begin
				err_ien <= i_reg_wdata[`BMS_NUM_M-1:0]; // [R05]
			end
			if (i_reg_addr == `BMS_OFF_APB) begin
				apb_secure <= i_reg_wdata[7:0]; // [R19]
			end
		end
	end

	// ------------------------------------------------------------
	// Register reads
	// ------------------------------------------------------------
	// Non-secure reads see zero rather than the real contents, which hides the
	// layout of the secure world from normal software.
	// Read mux; unmapped and non-secure reads give zero
	always_comb begin
		next_rdata = '0;
		if (sec_rd) begin
			for (int i = 0; i < `BMS_NUM_CFG; i++) begin
				if (i_reg_addr == `BMS_OFF_CFG0 + `BMS_RA_W'(4 * i)) begin
					next_rdata = region_cfg[i];
				end
			end
			for (int m = 0; m < `BMS_NUM_M; m++) begin
				if (i_reg_addr == `BMS_OFF_EADR0 + `BMS_RA_W'(4 * m)) begin
					next_rdata = err_addr[m];
				end
			end
			if (i_reg_addr == `BMS_OFF_STAT) begin
				next_rdata = {{(`BMS_DW-`BMS_NUM_M){1'b0}}, err_stat};
			end
			if (i_reg_addr == `BMS_OFF_IEN) begin
				next_rdata = {{(`BMS_DW-`BMS_NUM_M){1'b0}}, err_ien};
			end
			if (i_reg_addr == `BMS_OFF_APB) begin
				next_rdata = {24'h00_0000, apb_secure};
			end
		end
	end

	// Read data in the cycle after the strobe only
	always_ff @(posedge i_clk) begin
		if (!i_rst_n) begin
			o_reg_rdata <= '0;
		end else begin
			o_reg_rdata <= next_rdata; // [R01]
		end
	end

endmodule

// File: bms_filter_properties.sv
// Port checker of the bus matrix security filter
`include "bms_params.svh"
module bms_filter_checker
	import bms_pkg::*;
(
	input wire logic                  i_clk,
	input wire logic                  i_rst_n,
	input wire bms_req_t              i_req,
	input wire bms_serr_t             i_slv_err,
	input wire logic                  i_reg_wr,
	input wire logic                  i_reg_rd,
	input wire logic                  i_reg_secure,
	input wire logic [`BMS_DW-1:0]    o_reg_rdata,
	input wire bms_fwd_t              o_fwd,
	input wire logic [`BMS_NUM_M-1:0] o_err_resp,
	input wire logic                  o_sec_irq
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking @(posedge i_clk); endclocking
	default disable iff (!i_rst_n);
	// ----
	// Request path
	// ----
	fwd_cause_a: assert property (o_fwd.valid |-> $past(i_req.valid))
		else $error("forward without a request");
	fwd_attr_a: assert property (o_fwd.valid |-> o_fwd.addr == $past(i_req.addr) &&
		o_fwd.secure == $past(i_req.secure) && o_fwd.write == $past(i_req.write))
		else $error("forwarded attributes differ from the request");
	one_answer_a: assert property (i_req.valid && !i_slv_err.valid |=>
		o_fwd.valid ^ o_err_resp[$past(i_req.mid)])
		else $error("request not answered exactly once");
	slave_err_a: assert property (i_slv_err.valid |=> o_err_resp[$past(i_slv_err.mid)])
		else $error("slave error not answered");
	err_cause_a: assert property (|o_err_resp |-> $past(i_req.valid || i_slv_err.valid))
		else $error("error answer without a cause");
	ns_slave_a: assert property (i_req.valid && i_req.addr < `BMS_B_SEC && !i_slv_err.valid
		|=> o_fwd.valid && o_fwd.sid == `BMS_S_NS)
		else $error("open slave access not forwarded");
	sec_slave_a: assert property (i_req.valid && !i_req.secure &&
		i_req.addr[31:16] == 16'h0001 |=> !o_fwd.valid)
		else $error("non-secure access reached the secure slave");
	// ----
	// Register port and interrupt
	// ----
	ns_read_a: assert property (i_reg_rd && !i_reg_secure |=> o_reg_rdata == '0)
		else $error("non-secure register read returned data");
	idle_rdata_a: assert property (!i_reg_rd |=> o_reg_rdata == '0)
		else $error("read data outside a read answer");
	irq_cause_a: assert property ($rose(o_sec_irq) |-> $past(|o_err_resp) || $past(i_reg_wr, 2))
		else $error("interrupt rose without error or enable write");
endmodule

bind bms_filter bms_filter_checker u_chk (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_req(i_req),
	.i_slv_err(i_slv_err), .i_reg_wr(i_reg_wr), .i_reg_rd(i_reg_rd),
	.i_reg_secure(i_reg_secure), .o_reg_rdata(o_reg_rdata), .o_fwd(o_fwd),
	.o_err_resp(o_err_resp), .o_sec_irq(o_sec_irq));

// File: bms_filter_tb.sv
// Self-checking bench of the bus matrix security filter
`include "bms_params.svh"
`define CHK(g, e) cmp(32'(g), 32'(e))
module bms_filter_tb
	import bms_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	logic        i_clk = 1'b0;
	logic        i_rst_n = 1'b0;
	bms_req_t    i_req = '0;
	bms_serr_t   serr;
	logic [7:0]  i_reg_addr = '0;
	logic [31:0] i_reg_wdata = '0;
	logic        i_reg_wr = 1'b0;
	logic        i_reg_rd = 1'b0;
	logic        i_reg_secure = 1'b0;
	logic        fail = 1'b0;
	logic [1:0]  fail_mid = '0;
	logic [31:0] o_reg_rdata;
	bms_fwd_t    o_fwd;
	logic [3:0]  o_err_resp;
	logic        o_sec_irq;
	logic        rd_pend = 1'b0;
	logic [31:0] r;
	logic [9:0]  exp_q[$];
	logic [31:0] rd_q[$];
	int          bad_count = 0;
	int          total_checks = 0;
	int          cyc = 0;
	int          seed = 42151;
	wire  [9:0]  got = {o_fwd.valid,
		o_fwd.valid ? {o_fwd.sid, o_fwd.write, o_fwd.secure} : 5'h00, o_err_resp};

	bms_filter dut (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_req(i_req), .i_slv_err(serr),
		.i_reg_addr(i_reg_addr), .i_reg_wdata(i_reg_wdata), .i_reg_wr(i_reg_wr),
		.i_reg_rd(i_reg_rd), .i_reg_secure(i_reg_secure), .o_reg_rdata(o_reg_rdata),
		.o_fwd(o_fwd), .o_err_resp(o_err_resp), .o_sec_irq(o_sec_irq));
	bms_slave_model u_slv (.i_clk(i_clk), .i_fwd(o_fwd), .i_fail(fail),
		.i_fail_mid(fail_mid), .o_serr(serr));

	always #20 i_clk = ~i_clk;

	task automatic cmp(input logic [31:0] g, input logic [31:0] e);
		total_checks++;
		if (g !== e) begin
			bad_count++;
			$display("unexpected at %0t: got %h expected %h", $time, g, e);
		end
	endtask
	task automatic stop_test();
		$display("checks %0d mismatches %0d", total_checks, bad_count);
		if (bad_count == 0 && total_checks > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask
	// Register write and read on the plain register port
	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic s);
		@(posedge i_clk);
		i_reg_wr <= 1'b1;
		i_reg_addr <= a;
		i_reg_wdata <= d;
		i_reg_secure <= s;
		@(posedge i_clk);
		i_reg_wr <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, input logic s, input logic [31:0] e);
		@(posedge i_clk);
		i_reg_rd <= 1'b1;
		i_reg_addr <= a;
		i_reg_secure <= s;
		rd_q.push_back(e);
		@(posedge i_clk);
		i_reg_rd <= 1'b0;
	endtask
	// One request; wso is write, secure, allowed; allowed goes to slave sid with its attributes
	task automatic rq(input logic [1:0] m, input logic [31:0] a, input logic [2:0] wso,
		input logic [2:0] sid);
		@(posedge i_clk);
		i_req <= '{1'b1, m, a, wso[2], wso[1]};
		exp_q.push_back(wso[0] ? {1'b1, sid, wso[2], wso[1], 4'h0} : {6'h00, 4'h1 << m});
		@(posedge i_clk);
		i_req.valid <= 1'b0;
	endtask
	task automatic irq_is(input logic e);
		repeat (2) @(posedge i_clk);
		#1 `CHK(o_sec_irq, e);
	endtask

	// Compare each answer with the oldest note; cut a hang short
	always @(posedge i_clk) begin
		rd_pend <= i_reg_rd;
		if (rd_pend) `CHK(o_reg_rdata, rd_q.pop_front());
		if (o_fwd.valid || |o_err_resp) `CHK(got, exp_q.pop_front());
		cyc++;
		if (cyc == 3000) begin
			bad_count++;
			stop_test();
		end
	end

	initial begin
		repeat (12) @(posedge i_clk);
		i_rst_n <= 1'b1;
		rd(8'h00, 1'b1, 32'h0000_00FF);
		rd(8'h38, 1'b1, 32'h0000_00FF);
		rd(8'h3C, 1'b1, 32'h0);
		rd(8'h00, 1'b0, 32'h0);
		wr(8'h24, 32'hF, 1'b0);
		rd(8'h24, 1'b1, 32'h0);
		$display("test registers done");
		rq(2'h0, 32'h0000_0100, 3'b101, 3'h0);
		rq(2'h1, 32'h0800_0000, 3'b010, 3'h0);
		rq(2'h2, 32'h0001_0040, 3'b000, 3'h0);
		rq(2'h2, 32'h0001_0040, 3'b011, 3'h1);
		rq(2'h0, 32'h0010_0000, 3'b000, 3'h0);
		rq(2'h0, 32'h0010_0000, 3'b011, 3'h2);
		wr(8'h00, 32'hE0, 1'b1);
		rq(2'h0, 32'h0010_0000, 3'b000, 3'h0);
		rq(2'h0, 32'h0010_1000, 3'b001, 3'h2);
		wr(8'h00, 32'hC0, 1'b1);
		rq(2'h0, 32'h0010_0000, 3'b001, 3'h2);
		rq(2'h0, 32'h0010_1000, 3'b100, 3'h0);
		wr(8'h00, 32'hA0, 1'b1);
		rq(2'h0, 32'h0010_0000, 3'b001, 3'h2);
		rq(2'h0, 32'h0010_0000, 3'b111, 3'h2);
		rq(2'h0, 32'h0010_0000, 3'b100, 3'h0);
		rq(2'h3, 32'h0010_1000, 3'b000, 3'h0);
		rq(2'h3, 32'h0010_1000, 3'b011, 3'h2);
		wr(8'h04, 32'h0, 1'b1);
		rq(2'h1, 32'h2000_0000, 3'b001, 3'h3);
		rq(2'h1, 32'h2000_1000, 3'b010, 3'h0);
		wr(8'h08, 32'h0, 1'b1);
		rq(2'h1, 32'h4000_0000, 3'b001, 3'h4);
		rq(2'h1, 32'h4000_1000, 3'b000, 3'h0);
		rq(2'h1, 32'h4000_3000, 3'b011, 3'h4);
		wr(8'h14, 32'h0, 1'b1);
		rq(2'h1, 32'h4000_3000, 3'b000, 3'h0);
		rq(2'h1, 32'h4000_4000, 3'b010, 3'h0);
		wr(8'h08, 32'h100, 1'b1);
		rq(2'h1, 32'h4000_4000, 3'b011, 3'h4);
		rq(2'h1, 32'hF000_0000, 3'b000, 3'h0);
		rq(2'h1, 32'hF000_0000, 3'b011, 3'h5);
		wr(8'h38, 32'hFE, 1'b1);
		rq(2'h1, 32'hF000_0000, 3'b101, 3'h5);
		rq(2'h1, 32'hF000_1000, 3'b100, 3'h0);
		$display("test routing done");
		rd(8'h20, 1'b1, 32'hF);
		rd(8'h28, 1'b1, 32'h0010_0000);
		rd(8'h2C, 1'b1, 32'hF000_1000);
		wr(8'h20, 32'hF, 1'b1);
		rd(8'h20, 1'b1, 32'h0);
		wr(8'h24, 32'h1, 1'b1);
		rq(2'h1, 32'h0800_0000, 3'b010, 3'h0);
		irq_is(1'b0);
		rq(2'h0, 32'h0800_0000, 3'b010, 3'h0);
		irq_is(1'b1);
		wr(8'h20, 32'hF, 1'b1);
		irq_is(1'b0);
		$display("test capture done");
		@(posedge i_clk);
		fail <= 1'b1;
		fail_mid <= 2'h2;
		rq(2'h2, 32'h0000_0200, 3'b001, 3'h0);
		exp_q.push_back(10'h004);
		@(posedge i_clk);
		fail <= 1'b0;
		repeat (2) @(posedge i_clk);
		rd(8'h20, 1'b1, 32'h4);
		rd(8'h30, 1'b1, 32'h0000_0200);
		$display("test slave error done");
		repeat (20) begin
			r = $random(seed);
			rq(r[1:0], {16'h0000, r[31:16]}, {r[3:2], 1'b1}, 3'h0);
		end
		repeat (4) @(posedge i_clk);
		`CHK(exp_q.size() + rd_q.size(), 0);
		$display("test random done");
		stop_test();
	end
endmodule

// File: bms_params.svh
// Constants of the bus matrix security filter: sizes, offsets, fields, address map
`ifndef BMS_PARAMS_SVH
`define BMS_PARAMS_SVH
// ------------------------------------------------------------
// Sizes
// ------------------------------------------------------------
`define BMS_NUM_M      4
`define BMS_MID_W      2
`define BMS_NUM_S      6
`define BMS_SID_W      3
`define BMS_AW         32
`define BMS_DW         32
`define BMS_RA_W       8
`define BMS_NUM_CFG    8
`define BMS_CIDX_W     3
`define BMS_NUM_SCL    4
// ------------------------------------------------------------
// Register offsets
// ------------------------------------------------------------
`define BMS_OFF_CFG0   8'h00
`define BMS_OFF_STAT   8'h20
`define BMS_OFF_IEN    8'h24
`define BMS_OFF_EADR0  8'h28
`define BMS_OFF_APB    8'h38
// ------------------------------------------------------------
// Region configuration fields and reset values
// ------------------------------------------------------------
`define BMS_F_SPLIT    4:0
`define BMS_F_LOWSEC   5
`define BMS_F_RDSEC    6
`define BMS_F_WRSEC    7
`define BMS_F_SIZE     12:8
`define BMS_CFG_RST    32'h0000_00FF
`define BMS_IEN_RST    4'h0
`define BMS_APB_RST    8'hFF
`define BMS_MIN_SH     6'h0C
// ------------------------------------------------------------
// Slave address map and region indexes
// ------------------------------------------------------------
`define BMS_S_NS       3'h0
`define BMS_S_SEC      3'h1
`define BMS_S_INT      3'h2
`define BMS_S_EXT      3'h3
`define BMS_S_SCL      3'h4
`define BMS_S_APB      3'h5
`define BMS_B_NS       32'h0000_0000
`define BMS_B_SEC      32'h0001_0000
`define BMS_B_INT      32'h0010_0000
`define BMS_B_EXT      32'h2000_0000
`define BMS_B_SCL      32'h4000_0000
`define BMS_B_APB      32'hF000_0000
`define BMS_Z_NS       32'h0001_0000
`define BMS_Z_SEC      32'h0001_0000
`define BMS_Z_INT      32'h0010_0000
`define BMS_Z_EXT      32'h1000_0000
`define BMS_Z_SCL      32'h4000_0000
`define BMS_Z_APB      32'h0000_8000
`define BMS_CI_INT     3'h0
`define BMS_CI_EXT     3'h1
`define BMS_CI_SCL     3'h2
`define BMS_SCL_FIXSEC 3'h3
`define BMS_DMA_MID    2'h3
`define BMS_APB_SH     12
`endif

// File: bms_pkg.sv
// Types shared by the bus matrix security filter
`include "bms_params.svh"
package bms_pkg;
	typedef enum logic [2:0] {
		BMS_ST_NS,
		BMS_ST_SEC,
		BMS_ST_INT,
		BMS_ST_EXT,
		BMS_ST_SCL
	} bms_stype_t;

	typedef struct packed {
		logic                  valid;
		logic [`BMS_MID_W-1:0] mid;
		logic [`BMS_AW-1:0]    addr;
		logic                  write;
		logic                  secure;
	} bms_req_t;

	typedef struct packed {
		logic                  valid;
		logic [`BMS_SID_W-1:0] sid;
		logic [`BMS_AW-1:0]    addr;
		logic                  write;
		logic                  secure;
	} bms_fwd_t;

	typedef struct packed {
		logic                  valid;
		logic [`BMS_MID_W-1:0] mid;
		logic [`BMS_AW-1:0]    addr;
	} bms_serr_t;
endpackage

// File: bms_slave_model.sv
// Slave model that answers a forwarded transfer with an error on command
module bms_slave_model
	import bms_pkg::*;
(
	input  wire logic       i_clk,
	input  wire bms_fwd_t   i_fwd,
	input  wire logic       i_fail,
	input  wire logic [1:0] i_fail_mid,
	output bms_serr_t       o_serr
);
	timeunit 1ns;
	timeprecision 1ns;
	initial o_serr = '0;
	// Error pulse on command; idle lines toggle so stale values never match
	always @(posedge i_clk) begin
		if (i_fwd.valid && i_fail) begin
			o_serr <= '{1'b1, i_fail_mid, i_fwd.addr};
		end else begin
			o_serr <= '{1'b0, ~o_serr.mid, ~o_serr.addr};
		end
	end
endmodule
